// >>> rtl/tsf_pkg.sv
// Shared constants and types of the temperature sensor serial front end.
package tsf_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned CORE_CLK_HZ = 20_000_000;
	localparam int unsigned CLK_NS = 1_000_000_000 / CORE_CLK_HZ;
	localparam int unsigned SPIKE_NS = 50;
	localparam int unsigned SPIKE_RAW = (SPIKE_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned SPIKE_CYC = (SPIKE_RAW < 1) ? 1 : SPIKE_RAW;
	localparam int unsigned CONV_W = 24;

	// ****************************************
	// Serial protocol
	// ****************************************
	localparam logic [3:0] PREFIX_TEMP = 4'h9;
	localparam logic [3:0] PREFIX_EEPROM = 4'hA;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [7:0] PTR_TEMP = 8'h00;
	localparam logic [7:0] PTR_CFG = 8'h01;
	localparam logic [7:0] EEPROM_FILL = 8'hFF;
	localparam int unsigned RES_LSB = 5;
	localparam int unsigned RES_W = 2;
	localparam int unsigned TEMP_W = 12;
	localparam int unsigned FRAC_W = 4;
	localparam logic [1:0] LOAD_AT = 2'h2;
	localparam logic [1:0] LOAD_DONE = 2'h3;

	// ****************************************
	// Register bus
	// ****************************************
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_TEMP = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h8;
	localparam int unsigned STAT_BUSY = 8;
	localparam int unsigned STAT_RX_LSB = 16;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_RX = 5'h02,
		ST_RXACK = 5'h04,
		ST_TX = 5'h08,
		ST_TXACK = 5'h10
	} tsf_phase_t;

	typedef struct packed {
		tsf_phase_t phase;
		logic [3:0] bitCnt;
		logic [7:0] rxShift;
		logic [7:0] txShift;
		logic [7:0] lastRx;
		logic [7:0] pointer;
		logic [15:0] snapshot;
		logic sdaPull;
		logic firstByte;
		logic isRead;
		logic toTemp;
		logic toEeprom;
		logic ptrSent;
		logic txIdx;
		logic masterNack;
		logic prevScl;
		logic prevSda;
		logic [2:0] addrSync1;
		logic [2:0] addrSync2;
		logic [1:0] strapSync1;
		logic [1:0] strapSync2;
		logic [1:0] loadCnt;
		logic [1:0] resolution;
		logic [CONV_W-1:0] convCnt;
		logic [TEMP_W-1:0] tempResult;
		logic rdDone;
		logic [31:0] readData;
	} tsf_core_t;

endpackage

// >>> rtl/tsf_line_filter.sv
// Synchroniser and spike filter for one serial line.
`timescale 1ns/1ns
module tsf_line_filter #(
	parameter int unsigned STABLE_CYC = 1
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst,
	// Raw line and cleaned level.
	input wire logic lineIn,
	output logic lineOut
);
	localparam int unsigned CW = $clog2(STABLE_CYC + 1);
	localparam logic [CW-1:0] LIMIT = CW'(STABLE_CYC);

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic level;
		logic [CW-1:0] cnt;
	} tsf_filt_t;

	localparam tsf_filt_t FILT_RESET = '{sync1: 1'b1, sync2: 1'b1, level: 1'b1, cnt: '0};

	tsf_filt_t st;
	tsf_filt_t next_st;

	// The level flips only after the new value has been seen for more than STABLE_CYC samples.
	always_comb begin
		next_st = st;
		next_st.sync1 = lineIn;
		next_st.sync2 = st.sync1;
		if (st.sync2 == st.level) begin
			next_st.cnt = '0;
		end else if (st.cnt == LIMIT) begin
			next_st.level = st.sync2;
			next_st.cnt = '0;
		end else begin
			next_st.cnt = st.cnt + CW'(1);
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st <= FILT_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign lineOut = st.level;
endmodule

// >>> rtl/tsf_front_end.sv
// Serial slave front end, conversion sequencer and register slave of the sensor.
//
// Our own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns
// Function
// - Sample SDA on rising SCL; change driven SDA only after falling SCL.
// - Bytes shift most significant bit first, one bit per SCL clock.
// - Each byte is eight data clocks plus one acknowledge clock.
// - SDA changes only while SCL low; high-SCL change is START or STOP.
// - START is SDA falling with SCL high; ignore everything until START.
// - STOP is SDA rising with SCL high; return to idle.
// - Repeated START ends current transfer and begins a new one.
// - Bus idle only while SCL and SDA are both high.
// - Acknowledge a received byte by holding SDA low through clock nine.
// - Master high in acknowledge clock ends a read; release SDA.
// - Writes to the read-only temperature result are answered with NACK.
// - Address is prefix 1001 sensor or 1010 EEPROM plus three select pins.
// - First byte holds address in bits 7..1 and direction in bit 0.
// - Acknowledge matching address; on mismatch, NACK and go idle.
// - Convert continuously, updating the always readable result register.
// - Two-bit field selects 9, 10, 11 or 12 result bits.
// - Each higher resolution takes longer per conversion.
// - Resolution loads from the stored resolution bits after reset.
// - Any number of data bytes between START and STOP.
// - Twelve-bit two's complement result spans -128 to +127 degrees.
// - Both serial inputs are spike filtered before edges are seen.
// - SDA is open drain: pull low or release only.
// - Address select inputs read low when left open.
module tsf_front_end
	import tsf_pkg::*;
#(
	parameter int unsigned CONV_BASE_CYC = 4000
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst,
	// Serial link pins.
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	// Static straps.
	input wire logic addrSelBit2,
	input wire logic addrSelBit1,
	input wire logic addrSelBit0,
	input wire logic storedResolutionHi,
	input wire logic storedResolutionLo,
	// Converter sample.
	input wire logic [TEMP_W-1:0] adcSample,
	// Register bus.
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [1:0] addrHit(input logic [7:0] b, input logic [2:0] sel);
		addrHit = 2'b00;
		if (b[7:1] == {PREFIX_EEPROM, sel}) begin
			addrHit = 2'b10;
		end
		if (b[7:1] == {PREFIX_TEMP, sel}) begin
			addrHit = 2'b01;
		end
	endfunction

	function automatic logic [TEMP_W-1:0] resMask(input logic [1:0] res);
		resMask = {TEMP_W{1'b1}} << (2'h3 - res);
	endfunction

	function automatic logic [7:0] pickByte(input tsf_core_t s);
		if (s.toEeprom) begin
			pickByte = EEPROM_FILL;
		end else if (s.pointer == PTR_CFG) begin
			pickByte = 8'(s.resolution) << RES_LSB;
		end else if (s.txIdx) begin
			pickByte = s.snapshot[7:0];
		end else begin
			pickByte = s.snapshot[15:8];
		end
	endfunction

	localparam tsf_core_t CORE_RESET = '{
		phase: ST_IDLE, prevScl: 1'b1, prevSda: 1'b1, default: '0
	};

	tsf_core_t st;
	tsf_core_t next_st;
	logic sclF;
	logic sdaF;
	logic sclRise;
	logic sclFall;
	logic startSeen;
	logic stopSeen;
	logic byteDone;
	logic convEnd;
	logic [1:0] hit;
	logic [7:0] nextByte;
	logic [CONV_W-1:0] convLimit;

	// ****************************************
	// Line conditioning
	// ****************************************
	// Both lines share one filter depth so their relative timing is kept.
	tsf_line_filter #(
		.STABLE_CYC(SPIKE_CYC)
	) u_scl_filter (
		.core_clk(core_clk),
		.rst(rst),
		.lineIn(sclIn),
		.lineOut(sclF)
	);

	tsf_line_filter #(
		.STABLE_CYC(SPIKE_CYC)
	) u_sda_filter (
		.core_clk(core_clk),
		.rst(rst),
		.lineIn(sdaIn),
		.lineOut(sdaF)
	);

	assign sclRise = sclF && !st.prevScl;
	assign sclFall = !sclF && st.prevScl;
	// An SDA change while SCL stays high marks START or STOP.
	assign startSeen = sclF && st.prevScl && st.prevSda && !sdaF;
	assign stopSeen = sclF && st.prevScl && !st.prevSda && sdaF;
	assign byteDone = sclFall && (st.bitCnt == BITS_PER_BYTE);
	assign hit = addrHit(st.rxShift, st.addrSync2);
	assign nextByte = pickByte(st);
	// Conversion length doubles with each extra result bit.
	assign convLimit = (CONV_W'(CONV_BASE_CYC) << st.resolution) - CONV_W'(1);
	assign convEnd = (st.convCnt >= convLimit);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_st = st;
		next_st.prevScl = sclF;
		next_st.prevSda = sdaF;
		next_st.addrSync1 = {addrSelBit2, addrSelBit1, addrSelBit0};
		next_st.addrSync2 = st.addrSync1;
		next_st.strapSync1 = {storedResolutionHi, storedResolutionLo};
		next_st.strapSync2 = st.strapSync1;
		// The stored bits are taken once the synchroniser has filled after reset.
		if (st.loadCnt != LOAD_DONE) begin
			next_st.loadCnt = st.loadCnt + 2'h1;
			if (st.loadCnt == LOAD_AT) begin
				next_st.resolution = st.strapSync2;
			end
		end
		// Continuous conversions, result truncated to the chosen width.
		if (convEnd) begin
			next_st.convCnt = '0;
			next_st.tempResult = adcSample & resMask(st.resolution);
		end else begin
			next_st.convCnt = st.convCnt + CONV_W'(1);
		end
		// Register bus: reads answer one cycle later from a register.
		next_st.rdDone = avs_read && !st.rdDone;
		if (avs_read && !st.rdDone) begin
			next_st.readData = '0;
			case (avs_address)
				OFS_CTRL: begin
					next_st.readData[RES_W-1:0] = st.resolution;
				end
				OFS_TEMP: begin
					next_st.readData[TEMP_W-1:0] = st.tempResult;
				end
				OFS_STATUS: begin
					next_st.readData[4:0] = st.phase;
					next_st.readData[STAT_BUSY] = (st.phase != ST_IDLE);
					next_st.readData[STAT_RX_LSB+:8] = st.lastRx;
				end
				default: begin
					next_st.readData = '0;
				end
			endcase
		end
		if (avs_write && (avs_address == OFS_CTRL) && avs_byteenable[0]) begin
			next_st.resolution = avs_writedata[RES_W-1:0];
		end
		// Serial link.
		if (startSeen) begin
			// A repeated START drops whatever was going on.
			next_st.phase = ST_RX;
			next_st.bitCnt = '0;
			next_st.firstByte = 1'b1;
			next_st.ptrSent = 1'b0;
			next_st.sdaPull = 1'b0;
		end else if (stopSeen) begin
			next_st.phase = ST_IDLE;
			next_st.sdaPull = 1'b0;
		end else begin
			case (st.phase)
				ST_IDLE: begin
					next_st.sdaPull = 1'b0;
				end
				ST_RX: begin
					if (sclRise && (st.bitCnt != BITS_PER_BYTE)) begin
						next_st.rxShift = {st.rxShift[6:0], sdaF};
						next_st.bitCnt = st.bitCnt + 4'h1;
					end
					if (byteDone) begin
						next_st.lastRx = st.rxShift;
						next_st.phase = ST_RXACK;
						next_st.bitCnt = '0;
						if (st.firstByte) begin
							next_st.toTemp = hit[0];
							next_st.toEeprom = hit[1];
							next_st.isRead = st.rxShift[0];
							next_st.sdaPull = |hit;
							next_st.txIdx = 1'b0;
							if (st.rxShift[0]) begin
								next_st.snapshot = {st.tempResult, FRAC_W'(0)};
							end
						end else if (st.toEeprom) begin
							next_st.sdaPull = 1'b1;
						end else if (!st.ptrSent) begin
							next_st.sdaPull = (st.rxShift <= PTR_CFG);
							if (st.rxShift <= PTR_CFG) begin
								next_st.pointer = st.rxShift;
								next_st.ptrSent = 1'b1;
							end
						end else if (st.pointer == PTR_CFG) begin
							next_st.resolution = st.rxShift[RES_LSB+:RES_W];
							next_st.sdaPull = 1'b1;
						end else begin
							next_st.sdaPull = 1'b0;
						end
					end
				end
				ST_RXACK: begin
					if (sclFall) begin
						next_st.sdaPull = 1'b0;
						next_st.firstByte = 1'b0;
						next_st.bitCnt = '0;
						if (st.firstByte && !(st.toTemp || st.toEeprom)) begin
							next_st.phase = ST_IDLE;
						end else if (st.firstByte && st.isRead) begin
							next_st.phase = ST_TX;
							next_st.txShift = nextByte;
							next_st.sdaPull = !nextByte[7];
							next_st.txIdx = !st.txIdx;
						end else begin
							next_st.phase = ST_RX;
						end
					end
				end
				ST_TX: begin
					if (sclRise) begin
						next_st.bitCnt = st.bitCnt + 4'h1;
					end
					if (byteDone) begin
						next_st.phase = ST_TXACK;
						next_st.sdaPull = 1'b0;
					end else if (sclFall) begin
						next_st.txShift = {st.txShift[6:0], 1'b0};
						next_st.sdaPull = !st.txShift[6];
					end
				end
				ST_TXACK: begin
					if (sclRise) begin
						next_st.masterNack = sdaF;
					end
					if (sclFall) begin
						next_st.bitCnt = '0;
						if (st.masterNack) begin
							next_st.phase = ST_IDLE;
						end else begin
							next_st.phase = ST_TX;
							next_st.txShift = nextByte;
							next_st.sdaPull = !nextByte[7];
							next_st.txIdx = !st.txIdx;
						end
					end
				end
				default: begin
					next_st.phase = ST_IDLE;
					next_st.sdaPull = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st <= CORE_RESET;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// The pin is only ever pulled low; the pull-up makes the high level.
	assign sdaOut = 1'b0;
	assign sdaOe = st.sdaPull;
	assign avs_readdata = st.readData;
	assign avs_waitrequest = avs_read && !st.rdDone;

	// ****************************************
	// Checks
	// ****************************************
	AST_SDA_AFTER_FALL: assert property (@(posedge core_clk) disable iff (rst)
		(sdaOe != $past(sdaOe)) |-> $past(sclFall || startSeen || stopSeen))
		else $error("SDA drive changed without a falling SCL edge.");

	AST_START_RX: assert property (@(posedge core_clk) disable iff (rst)
		startSeen |=> (st.phase == ST_RX) && (st.bitCnt == 4'h0) && st.firstByte && !sdaOe)
		else $error("START did not open a new address byte.");

	AST_STOP_IDLE: assert property (@(posedge core_clk) disable iff (rst)
		stopSeen |=> (st.phase == ST_IDLE) && !sdaOe)
		else $error("STOP did not return to idle.");

	AST_IDLE_QUIET: assert property (@(posedge core_clk) disable iff (rst)
		(st.phase == ST_IDLE) && !startSeen |=> (st.phase == ST_IDLE) && !sdaOe)
		else $error("Idle left without START.");

	AST_ADDR_ACK: assert property (@(posedge core_clk) disable iff (rst)
		(st.phase == ST_RX) && byteDone && st.firstByte && !startSeen && !stopSeen
		&& (st.rxShift[7:1] == {PREFIX_TEMP, st.addrSync2})
		|=> sdaOe && (st.phase == ST_RXACK))
		else $error("Matching sensor address not acknowledged.");

	AST_ADDR_MISS: assert property (@(posedge core_clk) disable iff (rst)
		(st.phase == ST_RX) && byteDone && st.firstByte && !startSeen && !stopSeen
		&& (st.rxShift[7:4] != PREFIX_TEMP) && (st.rxShift[7:4] != PREFIX_EEPROM)
		|=> !sdaOe && (st.phase == ST_RXACK))
		else $error("Foreign address was acknowledged.");

	AST_ACK_HELD: assert property (@(posedge core_clk) disable iff (rst)
		(st.phase == ST_RXACK) && sdaOe && !sclFall && !startSeen && !stopSeen |=> sdaOe)
		else $error("Acknowledge released before the ninth clock ended.");

	AST_TEMP_WRITE_NACK: assert property (@(posedge core_clk) disable iff (rst)
		(st.phase == ST_RX) && byteDone && !st.firstByte && !st.toEeprom && st.ptrSent
		&& (st.pointer == PTR_TEMP) && !startSeen && !stopSeen |=> !sdaOe)
		else $error("Write to temperature result was acknowledged.");

	AST_NACK_ENDS_READ: assert property (@(posedge core_clk) disable iff (rst)
		(st.phase == ST_TXACK) && sclFall && st.masterNack && !startSeen && !stopSeen
		|=> ((st.phase == ST_IDLE) && !sdaOe) [*2])
		else $error("Read continued after master NACK.");

	AST_MSB_FIRST: assert property (@(posedge core_clk) disable iff (rst)
		(st.phase == ST_TX) && sclFall && !byteDone && !startSeen && !stopSeen
		|=> sdaOe == !$past(st.txShift[6]))
		else $error("Transmit bit order broken.");

	AST_SNAPSHOT_HELD: assert property (@(posedge core_clk) disable iff (rst)
		(st.phase == ST_TX) |=> $stable(st.snapshot))
		else $error("Result snapshot changed during a read.");

	AST_CONV_UPDATE: assert property (@(posedge core_clk) disable iff (rst)
		convEnd |=> st.tempResult == $past(adcSample & resMask(st.resolution)))
		else $error("Conversion result not stored.");

	AST_READ_ANSWER: assert property (@(posedge core_clk) disable iff (rst)
		avs_read && avs_waitrequest |=> !avs_waitrequest)
		else $error("Register read not answered in one cycle.");
endmodule

// >>> verif/tsf_i2c_master.sv
// Behavioural two-wire bus master that drives the sensor front end.
`timescale 1ns/1ns
module tsf_i2c_master (
	// Serial link.
	output logic scl,
	output logic sdaLow,
	input wire logic sdaLine
);
	localparam int CORE_NS = 50;
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
	// Moves to a point between rising core clock edges so no line changes on a sampling edge.
	task automatic align();
		if (($time % CORE_NS) != 0) begin
			#(CORE_NS - ($time % CORE_NS));
		end
	endtask
	// One bit: 300 ns low, 100 ns high; the long low phase covers the slave's filter latency.
	task automatic clkBit(input logic b, output logic s);
		logic s1;
		sdaLow = !b;
		#200 scl = 1'b1;
		#20 s1 = sdaLine;
		#60 s = sdaLine | s1;
		#20 scl = 1'b0;
		#100;
	endtask
	// Also serves as a repeated START when the clock is low.
	task automatic start();
		align();
		sdaLow = 1'b0;
		#200 scl = 1'b1;
		#200 sdaLow = 1'b1;
		#200 scl = 1'b0;
		#100;
	endtask
	task automatic stop();
		align();
		sdaLow = 1'b1;
		#200 scl = 1'b1;
		#200 sdaLow = 1'b0;
		#400;
	endtask
	// A data glitch seen by exactly one core sample while the bus is idle.
	task automatic spike();
		align();
		#10 sdaLow = 1'b1;
		#40 sdaLow = 1'b0;
		#400;
	endtask
	task automatic wrByte(input logic [7:0] d, output logic ack);
		logic s;
		align();
		for (int i = 7; i >= 0; i--) begin
			clkBit(d[i], s);
		end
		clkBit(1'b1, ack);
	endtask
	task automatic rdByte(input logic nack, output logic [7:0] d);
		logic s;
		align();
		for (int i = 7; i >= 0; i--) begin
			clkBit(1'b1, s);
			d[i] = s;
		end
		clkBit(nack, s);
	endtask
endmodule

// >>> verif/tsf_front_end_tb.sv
// Self-checking bench of the sensor serial front end.
`timescale 1ns/1ns
module tsf_front_end_tb
	import tsf_pkg::*;
();
	localparam logic [2:0] STRAP = 3'h5;
	localparam logic [7:0] ADDR_W = {PREFIX_TEMP, STRAP, 1'b0};
	localparam logic [7:0] ADDR_R = {PREFIX_TEMP, STRAP, 1'b1};
	logic core_clk;
	logic rst;
	logic [TEMP_W-1:0] adcSample;
	logic [3:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic sdaOut;
	logic sdaOe;
	logic scl;
	logic mstLow;
	wire logic sdaLine;
	int mismatches;
	int n_tests;
	int cycles;
	logic [31:0] rd;
	logic ack;
	logic [7:0] b;
	assign sdaLine = !((sdaOe && !sdaOut) || mstLow);
	tsf_front_end #(.CONV_BASE_CYC(20)) uut (.core_clk(core_clk), .rst(rst), .sclIn(scl),
		.sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSelBit2(STRAP[2]),
		.addrSelBit1(STRAP[1]), .addrSelBit0(STRAP[0]), .storedResolutionHi(1'b1),
		.storedResolutionLo(1'b0), .adcSample(adcSample), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	tsf_i2c_master mst (.scl(scl), .sdaLow(mstLow), .sdaLine(sdaLine));
	// ****************************************
	// Clock, timeout and line watch
	// ****************************************
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			stop_test();
		end
	end
	always @(sdaOe) begin
		if (scl === 1'b1 && cycles > 20) begin
			mismatches++;
			$display("[ERR] %0t data drive changed with clock high", $time);
		end
	end
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic avsWr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge core_clk);
		avs_write <= 1'b1;
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask
	task automatic avsRd(input logic [3:0] a, output logic [31:0] d);
		@(posedge core_clk);
		avs_read <= 1'b1;
		avs_address <= a;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read <= 1'b0;
	endtask
	task automatic stop_test();
		if (mismatches == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic tReset();
		chk(sdaOe, 0);
		avsRd(OFS_STATUS, rd);
		chk(rd[4:0], ST_IDLE);
		avsRd(OFS_CTRL, rd);
		chk(rd[1:0], 2'h2);
	endtask
	task automatic tNoStart();
		mst.spike();
		mst.wrByte(ADDR_W, ack);
		chk(ack, 1);
		avsRd(OFS_STATUS, rd);
		chk(rd[4:0], ST_IDLE);
	endtask
	task automatic tWrite();
		mst.start();
		mst.wrByte(ADDR_W, ack);
		chk(ack, 0);
		mst.wrByte(PTR_CFG, ack);
		chk(ack, 0);
		mst.wrByte(8'h60, ack);
		chk(ack, 0);
		mst.wrByte(8'h20, ack);
		chk(ack, 0);
		mst.stop();
		avsRd(OFS_CTRL, rd);
		chk(rd[1:0], 2'h1);
		avsRd(OFS_STATUS, rd);
		chk({rd[23:16], rd[4:0]}, {8'h20, 5'h01});
	endtask
	task automatic tRefuse();
		mst.start();
		mst.wrByte(ADDR_W, ack);
		mst.wrByte(PTR_TEMP, ack);
		chk(ack, 0);
		mst.wrByte(8'h55, ack);
		chk(ack, 1);
		mst.start();
		mst.wrByte({PREFIX_TEMP, 3'h4, 1'b0}, ack);
		chk(ack, 1);
		mst.wrByte(PTR_CFG, ack);
		chk(ack, 1);
		mst.start();
		mst.wrByte({PREFIX_EEPROM, STRAP, 1'b1}, ack);
		chk(ack, 0);
		mst.rdByte(1'b1, b);
		chk(b, EEPROM_FILL);
		mst.stop();
		avsWr(OFS_CTRL, 32'h0000_0003, 4'hE);
		avsRd(OFS_CTRL, rd);
		chk(rd[1:0], 2'h1);
	endtask
	task automatic tConvert();
		@(posedge core_clk);
		adcSample <= 12'hA5C;
		for (int r = 0; r < 4; r++) begin
			avsWr(OFS_CTRL, 32'(r), 4'hF);
			repeat (400) @(posedge core_clk);
			avsRd(OFS_TEMP, rd);
			chk(rd[11:0], 12'hA5C & (12'hFFF << (3 - r)));
		end
	endtask
	task automatic tRead();
		@(posedge core_clk);
		adcSample <= 12'h5C3;
		repeat (400) @(posedge core_clk);
		mst.start();
		mst.wrByte(ADDR_W, ack);
		mst.wrByte(PTR_TEMP, ack);
		mst.start();
		mst.wrByte(ADDR_R, ack);
		chk(ack, 0);
		mst.rdByte(1'b0, b);
		chk(b, 8'h5C);
		@(posedge core_clk);
		adcSample <= 12'h123;
		repeat (400) @(posedge core_clk);
		mst.rdByte(1'b1, b);
		chk(b, 8'h30);
		#400;
		chk(sdaOe, 0);
		mst.stop();
		avsRd(OFS_TEMP, rd);
		chk(rd[11:0], 12'h123);
	endtask
	initial begin
		rst = 1'b1;
		adcSample = 12'h000;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'hF;
		cycles = 0;
		mismatches = 0;
		n_tests = 0;
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		repeat (4) @(posedge core_clk);
		tReset();
		tNoStart();
		tWrite();
		tRefuse();
		tConvert();
		tRead();
		stop_test();
	end
endmodule
